// file: flash_volatile_config_lock.sv
// volatile interface/protect configuration register with link decoder
`timescale 1ns/1ps
`include "flash_cfg_defines.svh"

// Behaviour
// - bits 5,3,2 mirror the one-time settings
// - quad bit selects four-lane data width
// - quad: lane three is reset when deselected
// - quad: write-protect level forced inactive high
// - serial reads still work
// - quad cannot clear during instruction mode
// - legacy write updates volatile and default together
// - return register for both read commands
// - lock freezes protect fields and OTP
// - locked writes silently ignored, no error
// - locked OTP program fails with error
// - unlocked: protection and OTP writable
// - lock clears only on power/hardware reset
// - software reset keeps the lock
// - lock loads from default at power-on
// - lock settable with other bits together
// - lock never blocks quad
// - reset loads quad from its default
module flash_volatile_config_lock (
    input  wire logic       clk_i,          // core clock
    input  wire logic       reset_i,        // power-on or hardware reset
    input  wire logic       sck_i,          // link clock
    input  wire logic       cs_n_i,         // chip select pin
    input  wire logic       si_i,           // serial data in, lane zero
    input  wire logic       wp_n_i,         // write-protect / lane two pin
    input  wire logic       lane_three_i,   // lane three / reset pin
    input  wire logic [2:0] otp_bits_i,     // {origin, source, param} OTP
    input  wire logic       four_lane_default_i,  // nonvolatile quad
    input  wire logic       lock_default_i,       // nonvolatile lock
    input  wire logic       instr_mode_i,   // four-lane instruction mode
    input  wire logic       soft_reset_i,   // software reset pulse
    input  wire logic       otp_prog_req_i, // OTP program request pulse
    input  wire logic       otp_in_area_i,  // request hits the OTP area
    output logic            so_o,           // serial data out
    output logic            so_oe_o,        // drive enable for so_o
    output logic [7:0]      cfg_o,          // current register value
    output logic            quad_mode_o,    // four-lane data path select
    output logic            wp_level_o,     // internal write-protect level
    output logic            hw_init_o,      // reset seen on lane three
    output logic            nv_quad_wr_o,   // write default quad pulse
    output logic            nv_quad_val_o,  // value for that write
    output logic            otp_cfg_wr_o,   // write OTP settings pulse
    output logic [2:0]      otp_cfg_val_o,  // value for that write
    output logic            sr_wr_o,        // status write pulse
    output logic [7:0]      sr_val_o,       // status byte written
    output logic            bp_wr_en_o,     // block-protect field writable
    output logic            otp_prog_go_o,  // OTP program allowed pulse
    output logic            program_error_o // OTP program refused pulse
);
    // ---------------- link clock domain ----------------
    logic [2:0]                 phase_r;     // bit within current byte
    logic [2:0]                 bytes_r;     // whole bytes so far, capped
    logic [7:0]                 shift_r;     // incoming bits
    flash_cfg_pkg::cfg_byte_t   cmd_r;       // opcode of the frame
    flash_cfg_pkg::cfg_byte_t   stat_byte_r; // first legacy data byte
    flash_cfg_pkg::cfg_byte_t   cfg_byte_r;  // second legacy / ADDRESSED_REGISTER_WRITE data
    logic [23:0]                addr_r;      // address of addressed cmds
    logic                       stat_v_r;    // first data byte captured
    logic                       cfg_v_r;     // config byte captured
    logic [7:0]                 mirror_r;    // link-side register copy
    logic [1:0]                 mtgl_sync_r; // request toggle synchroniser
    logic                       mack_r;      // acknowledge toggle
    logic [7:0]                 hold_r;      // value offered, core clock
    logic                       hold_tgl_r;  // offer toggle, core clock
    logic [7:0]                 next_byte;   // shift_r with current bit

    assign next_byte = {shift_r[6:0], si_i};

    // bit and byte counters restart whenever chip select rises
    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            phase_r <= 3'h0;
            bytes_r <= 3'h0;
        end else begin
            phase_r <= phase_r + 3'h1;
            if (phase_r == `PHASE_LAST && bytes_r != `BYTES_ADDRESSED_REGISTER_WRITE_DATA) begin
                bytes_r <= bytes_r + 3'h1;
            end
        end
    end

    // field capture; valid flags clear on the first edge of a frame
    // so they stay put while the core domain commits after the frame
    always_ff @(posedge sck_i) begin
        shift_r <= next_byte;
        if (phase_r == 3'h0 && bytes_r == 3'h0) begin
            stat_v_r <= 1'b0;
            cfg_v_r  <= 1'b0;
        end
        if (phase_r == `PHASE_LAST) begin
            if (bytes_r == 3'h0) begin
                cmd_r <= next_byte;
            end else if (cmd_r == `OP_LEGACY_REG_WRITE) begin
                if (bytes_r == `BYTES_CMD) begin
                    stat_byte_r <= next_byte;
                    stat_v_r    <= 1'b1;
                end else if (bytes_r == `BYTES_WRR_STATUS) begin
                    cfg_byte_r <= next_byte;
                    cfg_v_r    <= 1'b1;
                end
            end else if (bytes_r < `BYTES_ADDR_DONE) begin
                addr_r <= {addr_r[15:0], next_byte};
            end else if (bytes_r == `BYTES_ADDR_DONE
                         && cmd_r == `OP_ADDR_REG_WRITE) begin
                cfg_byte_r <= next_byte;
                cfg_v_r    <= 1'b1;
            end
        end
    end

    // mirror refresh: toggle handshake, data held stable by the core side;
    // the core reset clears it while the link clock stands still, so the
    // toggles on both sides start equal and the handshake cannot stall
    always_ff @(posedge sck_i or posedge reset_i) begin
        if (reset_i) begin
            {mtgl_sync_r, mack_r, mirror_r} <= '0;
        end else begin
            mtgl_sync_r <= {mtgl_sync_r[0], hold_tgl_r};
            if (mtgl_sync_r[1] != mack_r) begin
                mirror_r <= hold_r;
                mack_r   <= mtgl_sync_r[1];
            end
        end
    end

    // read data leaves on falling edges, most significant bit first;
    // only the serial lines si_i and so_o are used, so serial reads work in quad mode too
    always_ff @(negedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            so_oe_o <= 1'b0;
            so_o    <= 1'b0;
        end else if ((cmd_r == `OP_CONFIG_READ && bytes_r >= `BYTES_CMD)
                     || (cmd_r == `OP_ADDR_REG_READ
                         && bytes_r >= `BYTES_ADDR_DONE)) begin
            so_oe_o <= 1'b1;
            if (cmd_r == `OP_ADDR_REG_READ
                && addr_r != `ADDR_CFG_VOLATILE) begin
                so_o <= 1'b0;
            end else begin
                so_o <= mirror_r[3'h7 - phase_r];
            end
        end else begin
            so_oe_o <= 1'b0;
        end
    end

    // ---------------- core clock domain ----------------
    logic [2:0] pins_sync;   // {cs_n, wp_n, lane three} after two stages
    logic       cs_prev_r;   // previous synced chip select
    logic       init_pend_r; // load defaults on the next cycle
    logic       quad_r;      // four-lane select
    logic       lock_r;      // protection lock
    logic [2:0] shadow_r;    // {origin, source, param} shadows
    logic [1:0] mack_sync_r; // acknowledge synchroniser
    logic       frame_end;   // chip select just rose
    logic       hw_init;     // reset level on lane three while deselected
    logic [7:0] cfg_val;     // assembled register value
    flash_cfg_pkg::commit_kind_t kind;

    bit_sync #(
        .WIDTH (3)
    ) u_pin_sync (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .async_i     ({cs_n_i, wp_n_i, lane_three_i}),
        .reset_val_i (3'h7),
        .sync_o      (pins_sync)
    );

    assign frame_end = pins_sync[2] && !cs_prev_r;
    // lane three carries data while selected, reset when deselected
    assign hw_init   = pins_sync[2] && !pins_sync[0];

    // reserved bits 7,6,4 fixed at zero
    assign cfg_val = {2'b00, shadow_r[2], 1'b0, shadow_r[1],
                      shadow_r[0], quad_r, lock_r};

    // classify the finished frame; link fields are stable while deselected
    always_comb begin
        kind = flash_cfg_pkg::CK_NONE;
        if (frame_end && cfg_v_r) begin
            if (cmd_r == `OP_LEGACY_REG_WRITE) begin
                kind = flash_cfg_pkg::CK_LEGACY;
            end else if (cmd_r == `OP_ADDR_REG_WRITE
                         && addr_r == `ADDR_CFG_VOLATILE) begin
                kind = flash_cfg_pkg::CK_ADDR_VOL;
            end else if (cmd_r == `OP_ADDR_REG_WRITE
                         && addr_r == `ADDR_CFG_NONVOLATILE) begin
                kind = flash_cfg_pkg::CK_ADDR_NV;
            end
        end
    end

    // pin history: chip select edge and defaults pending after an init
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cs_prev_r   <= 1'b1;
            init_pend_r <= 1'b1;
        end else begin
            cs_prev_r   <= pins_sync[2];
            init_pend_r <= hw_init;
        end
    end

    // shadows follow the OTP settings every cycle
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            shadow_r <= 3'h0;
        end else begin
            shadow_r <= otp_bits_i;
        end
    end

    // protection lock: set by writes, cleared only by reset or init
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            lock_r <= 1'b0;
        end else if (init_pend_r) begin
            lock_r <= lock_default_i;
        end else if ((kind == flash_cfg_pkg::CK_LEGACY
                      || kind == flash_cfg_pkg::CK_ADDR_VOL)
                     && cfg_byte_r[`CFG_LOCK_BIT]) begin
            lock_r <= 1'b1;
        end
        // soft reset intentionally absent here
    end

    // four-lane select; never gated by the lock
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            quad_r <= 1'b0;
        end else if (init_pend_r || soft_reset_i) begin
            quad_r <= four_lane_default_i;
        end else if ((kind == flash_cfg_pkg::CK_LEGACY
                      || kind == flash_cfg_pkg::CK_ADDR_VOL)
                     && (cfg_byte_r[`CFG_QUAD_BIT] || !instr_mode_i)) begin
            quad_r <= cfg_byte_r[`CFG_QUAD_BIT];
        end
    end

    // default quad write: legacy writes go through the default unless they clear quad in instruction mode
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            nv_quad_wr_o  <= 1'b0;
            nv_quad_val_o <= 1'b0;
        end else begin
            nv_quad_wr_o  <= (kind == flash_cfg_pkg::CK_LEGACY
                              || kind == flash_cfg_pkg::CK_ADDR_NV)
                             && (cfg_byte_r[`CFG_QUAD_BIT]
                                 || !instr_mode_i);
            nv_quad_val_o <= cfg_byte_r[`CFG_QUAD_BIT];
        end
    end

    // OTP setting writes pass only while unlocked; the lock value before
    // this command gates them, so lock and settings can go together
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            otp_cfg_wr_o  <= 1'b0;
            otp_cfg_val_o <= 3'h0;
        end else begin
            otp_cfg_wr_o  <= (kind == flash_cfg_pkg::CK_LEGACY
                              || kind == flash_cfg_pkg::CK_ADDR_NV)
                             && !lock_r;
            otp_cfg_val_o <= {cfg_byte_r[`CFG_ORIGIN_BIT],
                              cfg_byte_r[`CFG_SOURCE_BIT],
                              cfg_byte_r[`CFG_PARAM_BIT]};
        end
    end

    // status byte of a legacy write; block-protect field frozen when locked
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sr_wr_o    <= 1'b0;
            sr_val_o   <= `CFG_BYTE_RESET;
            bp_wr_en_o <= 1'b1;
        end else begin
            sr_wr_o    <= frame_end && stat_v_r
                          && cmd_r == `OP_LEGACY_REG_WRITE;
            sr_val_o   <= stat_byte_r;
            bp_wr_en_o <= !lock_r;
        end
    end

    // OTP programming: refused with error inside the area when locked
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            otp_prog_go_o   <= 1'b0;
            program_error_o <= 1'b0;
        end else begin
            otp_prog_go_o   <= otp_prog_req_i
                               && !(otp_in_area_i && lock_r);
            program_error_o <= otp_prog_req_i
                               && otp_in_area_i && lock_r;
        end
    end

    // data path width and write-protect level
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            quad_mode_o <= 1'b0;
            wp_level_o  <= 1'b1;
            hw_init_o   <= 1'b0;
            cfg_o       <= `CFG_BYTE_RESET;
        end else begin
            quad_mode_o <= quad_r;
            wp_level_o  <= quad_r ? 1'b1 : pins_sync[1];
            hw_init_o   <= hw_init;
            cfg_o       <= cfg_val;
        end
    end

    // offer a new value to the link side only after the last was taken,
    // so the held word never changes while it is being sampled
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            hold_r      <= `CFG_BYTE_RESET;
            hold_tgl_r  <= 1'b0;
            mack_sync_r <= 2'b00;
        end else begin
            mack_sync_r <= {mack_sync_r[0], mack_r};
            if (mack_sync_r[1] == hold_tgl_r && hold_r != cfg_val) begin
                hold_r     <= cfg_val;
                hold_tgl_r <= !hold_tgl_r;
            end
        end
    end
endmodule // flash_volatile_config_lock

// file: flash_cfg_defines.svh
// constants for the volatile interface/protect configuration block
`ifndef FLASH_CFG_DEFINES_SVH
`define FLASH_CFG_DEFINES_SVH

// link command opcodes
`define OP_LEGACY_REG_WRITE   8'h01
`define OP_CONFIG_READ        8'h35
`define OP_ADDR_REG_READ      8'h65
`define OP_ADDR_REG_WRITE     8'h71

// register addresses used by the addressed commands (arbitrary choice)
`define ADDR_CFG_VOLATILE     24'h000102
`define ADDR_CFG_NONVOLATILE  24'h000002

// field positions in the configuration byte
`define CFG_LOCK_BIT          0
`define CFG_QUAD_BIT          1
`define CFG_PARAM_BIT         2
`define CFG_SOURCE_BIT        3
`define CFG_ORIGIN_BIT        5

// byte counts at which command fields are complete
`define BYTES_CMD             3'h1
`define BYTES_WRR_STATUS      3'h2
`define BYTES_WRR_CONFIG      3'h3
`define BYTES_ADDR_DONE       3'h4
`define BYTES_ADDRESSED_REGISTER_WRITE_DATA       3'h5

// reset value and last bit phase
`define CFG_BYTE_RESET        8'h00
`define PHASE_LAST            3'h7

`endif

// file: flash_cfg_pkg.sv
// types shared by the configuration block
package flash_cfg_pkg;
    // kind of register update taken at the end of a frame
    typedef enum logic [1:0] {
        CK_NONE,
        CK_LEGACY,
        CK_ADDR_VOL,
        CK_ADDR_NV
    } commit_kind_t;

    // one byte of the link
    typedef logic [7:0] cfg_byte_t;
endpackage

// file: bit_sync.sv
// two flip-flop level synchroniser, one stage pair per bit
`timescale 1ns/1ps
module bit_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    input  wire logic [WIDTH-1:0] async_i,
    input  wire logic [WIDTH-1:0] reset_val_i,
    output logic      [WIDTH-1:0] sync_o
);
    // first stage feeds only the second stage
    logic [WIDTH-1:0] meta_r;

    // an empty chain is refused at elaboration
    if (WIDTH < 1) begin : g_width_check
        $error("bit_sync needs at least one bit");
    end

    // sampling chain, reset to the idle level of each pin
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            meta_r <= reset_val_i;
            sync_o <= reset_val_i;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end
endmodule // bit_sync

// file: flash_cfg_props.sv
// assertion checker for the volatile configuration register
`timescale 1ns/1ps
module flash_cfg_props (
    input wire logic       clk_i,
    input wire logic       reset_i,
    input wire logic       cs_n_i,
    input wire logic       lane_three_i,
    input wire logic [2:0] otp_bits_i,
    input wire logic       four_lane_default_i,
    input wire logic       instr_mode_i,
    input wire logic       soft_reset_i,
    input wire logic       otp_prog_req_i,
    input wire logic       otp_in_area_i,
    input wire logic       so_oe_o,
    input wire logic [7:0] cfg_o,
    input wire logic       quad_mode_o,
    input wire logic       wp_level_o,
    input wire logic       nv_quad_wr_o,
    input wire logic       bp_wr_en_o,
    input wire logic       otp_prog_go_o,
    input wire logic       program_error_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // defaults need two edges after release to show on cfg_o
    sequence settled_s;
        (!reset_i) [*3];
    endsequence
    // in-area program request seen at the clock edge
    sequence otp_req_s;
        otp_prog_req_i && otp_in_area_i;
    endsequence
    a_reserved_read_zero: assert property (
        cfg_o[7:6] == 2'h0 && !cfg_o[4])
        else $error("reserved configuration bits not zero");
    a_shadow_follows_otp: assert property (
        settled_s ##0 ($stable(otp_bits_i)) [*4]
        |-> {cfg_o[5], cfg_o[3:2]} == otp_bits_i)
        else $error("shadow bits differ from one-time settings");
    a_quad_forces_wp: assert property (
        quad_mode_o && $past(quad_mode_o) |-> wp_level_o)
        else $error("write-protect level low in four-lane mode");
    // a low lane three reaches cfg_o four edges later, so five samples
    a_lock_holds_set: assert property (
        lane_three_i [*5] ##0 cfg_o[0] |=> cfg_o[0])
        else $error("lock cleared without a hardware reset");
    a_lock_blocks_bp: assert property (
        cfg_o[0] && $past(cfg_o[0]) |-> !bp_wr_en_o)
        else $error("block-protect writable while locked");
    a_locked_otp_fails: assert property (
        settled_s ##0 otp_req_s ##0 cfg_o[0]
        |=> program_error_o && !otp_prog_go_o)
        else $error("locked OTP program not refused");
    a_free_otp_runs: assert property (
        settled_s ##0 otp_req_s ##0 !cfg_o[0]
        |=> otp_prog_go_o && !program_error_o)
        else $error("unlocked OTP program not allowed");
    a_idle_no_drive: assert property (
        cs_n_i |-> !so_oe_o)
        else $error("serial output driven while deselected");
    a_nv_write_pulse: assert property (
        nv_quad_wr_o |=> !nv_quad_wr_o)
        else $error("default write pulse longer than one cycle");
    a_soft_quad_reload: assert property (
        settled_s ##0 soft_reset_i && four_lane_default_i && !instr_mode_i
        |-> ##[1:3] quad_mode_o)
        else $error("software reset did not reload quad");
endmodule // flash_cfg_props

bind flash_volatile_config_lock flash_cfg_props props_i (.clk_i, .reset_i,
    .cs_n_i, .lane_three_i, .otp_bits_i, .four_lane_default_i, .instr_mode_i,
    .soft_reset_i, .otp_prog_req_i, .otp_in_area_i, .so_oe_o, .cfg_o,
    .quad_mode_o, .wp_level_o, .nv_quad_wr_o, .bp_wr_en_o, .otp_prog_go_o,
    .program_error_o);

// file: flash_host_model.sv
// host-side serial link driver acting as the flash controller
`timescale 1ns/1ps
module flash_host_model (
    output logic      sck_o,
    output logic      cs_n_o,
    output logic      si_o,
    input  wire logic so_i,
    input  wire logic so_oe_i
);
    int oe_miss; // read bits taken while the device was not driving
    // link clock stands still and chip select is high outside frames
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b0;
        si_o = 1'b0;
        oe_miss = 0;
        // a clean rise after time zero clears the link counters
        #2 cs_n_o = 1'b1;
    end
    // single-lane frames only, no four-lane command is ever sent
    task automatic frame(input logic [39:0] tx, input int nout,
                         input int nin, output logic [7:0] rx);
        rx = 8'h00;
        #3 cs_n_o = 1'b0;
        for (int i = 0; i < nout + nin; i++) begin
            // after the command the lane is released, so it toggles
            si_o = (i < nout) ? tx[39-i] : ~si_o;
            #6 sck_o = 1'b1;
            if (i >= nout) begin
                rx = {rx[6:0], so_i};
                if (so_oe_i !== 1'b1) oe_miss++;
            end
            #6 sck_o = 1'b0;
        end
        #6 cs_n_o = 1'b1;
        si_o = ~si_o;
        #50; // deselect gap well above the required four core cycles
    endtask
endmodule // flash_host_model

// file: tb_flash_volatile_config_lock.sv
// self-checking bench for the volatile configuration register
`timescale 1ns/1ps
module tb_flash_volatile_config_lock;
    logic clk_i, reset_i, sck_i, cs_n_i, si_i, wp_n_i, lane_three_i;
    logic [2:0] otp_bits_i, otp_cfg_val_o;
    logic four_lane_default_i, lock_default_i, instr_mode_i, soft_reset_i;
    logic otp_prog_req_i, otp_in_area_i, so_o, so_oe_o, quad_mode_o;
    logic [7:0] cfg_o, sr_val_o, rx, sr_seen;
    logic wp_level_o, hw_init_o, nv_quad_wr_o, nv_quad_val_o, otp_cfg_wr_o;
    logic sr_wr_o, bp_wr_en_o, otp_prog_go_o, program_error_o, nv_seen;
    int fail_count, checked, n_sr, n_nv, n_otp, n_err, n_go, n_hw;

    flash_volatile_config_lock dut (.clk_i, .reset_i, .sck_i, .cs_n_i, .si_i,
        .wp_n_i, .lane_three_i, .otp_bits_i, .four_lane_default_i,
        .lock_default_i, .instr_mode_i, .soft_reset_i, .otp_prog_req_i,
        .otp_in_area_i, .so_o, .so_oe_o, .cfg_o, .quad_mode_o, .wp_level_o,
        .hw_init_o, .nv_quad_wr_o, .nv_quad_val_o, .otp_cfg_wr_o,
        .otp_cfg_val_o, .sr_wr_o, .sr_val_o, .bp_wr_en_o, .otp_prog_go_o,
        .program_error_o);
    flash_host_model host (.sck_o(sck_i), .cs_n_o(cs_n_i), .si_o(si_i),
        .so_i(so_o), .so_oe_i(so_oe_o));

    always #5 clk_i = ~clk_i; // 100 MHz core clock
    // count one-cycle pulses and keep the values they carry
    always @(posedge clk_i) begin
        if (sr_wr_o === 1'b1) begin n_sr++; sr_seen = sr_val_o; end
        if (nv_quad_wr_o === 1'b1) begin n_nv++; nv_seen = nv_quad_val_o; end
        if (otp_cfg_wr_o === 1'b1) n_otp++;
        if (program_error_o === 1'b1) n_err++;
        if (otp_prog_go_o === 1'b1) n_go++;
        if (hw_init_o === 1'b1) n_hw++;
    end
    // nonvolatile store: one-time bits can only be set
    always @(negedge clk_i) begin
        if (nv_quad_wr_o === 1'b1) four_lane_default_i = nv_quad_val_o;
        if (otp_cfg_wr_o === 1'b1) otp_bits_i = otp_bits_i | otp_cfg_val_o;
    end

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic settle; repeat (8) @(negedge clk_i); endtask
    task automatic wr_addr(input logic [7:0] d); // addressed write
        host.frame({8'h71, 24'h000102, d}, 40, 0, rx);
        settle;
    endtask
    task automatic wr_legacy(input logic [7:0] st, input logic [7:0] cf);
        host.frame({8'h01, st, cf, 16'h0000}, 24, 0, rx);
        settle;
    endtask
    task automatic otp_req;
        @(negedge clk_i) {otp_prog_req_i, otp_in_area_i} = 2'b11;
        @(negedge clk_i) otp_prog_req_i = 1'b0;
        repeat (2) @(negedge clk_i);
    endtask
    task automatic t_reset;
        check("cfg", cfg_o, 8'h26);
        check("quad", 8'(quad_mode_o), 8'h01);
        check("wp", 8'(wp_level_o), 8'h01);
    endtask
    task automatic t_reads;
        host.frame({8'h35, 32'h0}, 8, 8, rx);
        check("rd35", rx, 8'h26);
        host.frame({8'h65, 24'h000102, 8'h00}, 32, 8, rx);
        check("rd65", rx, 8'h26);
        host.frame({8'h65, 24'h000050, 8'h00}, 32, 8, rx);
        check("rd65 other", rx, 8'h00);
    endtask
    task automatic t_addressed_register_write;
        @(negedge clk_i) wp_n_i = 1'b0;
        wr_addr(8'hD0);
        check("cfg", cfg_o, 8'h24);
        check("nv count", 8'(n_nv), 8'h00);
        check("wp", 8'(wp_level_o), 8'h00);
        wr_addr(8'h02);
        check("quad", 8'(quad_mode_o), 8'h01);
        check("wp quad", 8'(wp_level_o), 8'h01);
        instr_mode_i = 1'b1;
        wr_addr(8'h00);
        check("cfg held", cfg_o, 8'h26);
        instr_mode_i = 1'b0;
    endtask
    task automatic t_legacy;
        wr_legacy(8'h80, 8'h00);
        check("sr count", 8'(n_sr), 8'h01);
        check("sr value", sr_seen, 8'h80);
        check("nv value", {n_nv[6:0], nv_seen}, 8'h02);
        check("cfg", cfg_o, 8'h24);
    endtask
    task automatic t_lock;
        wr_legacy(8'h00, 8'h0B);
        check("cfg", cfg_o, 8'h2F);
        check("otp count", 8'(n_otp), 8'h02);
        check("bp", 8'(bp_wr_en_o), 8'h00);
        wr_addr(8'h00);
        check("cfg locked", cfg_o, 8'h2D);
        check("err locked", 8'(n_err), 8'h00);
        otp_req;
        check("err count", 8'(n_err), 8'h01);
        @(negedge clk_i) soft_reset_i = 1'b1;
        @(negedge clk_i) soft_reset_i = 1'b0;
        settle;
        check("cfg soft", cfg_o, 8'h2F);
    endtask
    task automatic t_unlock;
        lane_three_i = 1'b0;
        repeat (6) @(negedge clk_i);
        lane_three_i = 1'b1;
        settle;
        check("hw init", 8'(n_hw != 0), 8'h01);
        check("cfg", cfg_o, 8'h2E);
        otp_req;
        check("go count", 8'(n_go), 8'h01);
        host.frame({8'h35, 32'h0}, 8, 8, rx);
        check("rd quad", rx, 8'h2E);
        check("oe", 8'(host.oe_miss), 8'h00);
        // nonvolatile address: the default changes, the volatile copy stays
        host.frame({8'h71, 24'h000002, 8'h20}, 40, 0, rx);
        settle;
        check("nv addr", {n_nv[6:0], nv_seen}, 8'h06);
        check("cfg nv addr", cfg_o, 8'h2E);
    endtask
    task automatic tally_and_finish;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // watchdog cuts a hang short
    initial begin
        #300000;
        fail_count++;
        tally_and_finish;
    end
    // main sequence: reset, then one task per scenario
    initial begin
        {clk_i, reset_i, wp_n_i, lane_three_i} = 4'h3;
        {otp_bits_i, four_lane_default_i, lock_default_i} = 5'h16;
        {instr_mode_i, soft_reset_i, otp_prog_req_i, otp_in_area_i} = 4'h0;
        {fail_count, checked, n_sr, n_nv, n_otp, n_err, n_go, n_hw} = '0;
        // reset rises just after time zero so edge-triggered resets see it
        #1 reset_i = 1'b1;
        repeat (3) @(negedge clk_i);
        reset_i = 1'b0;
        repeat (12) @(negedge clk_i);
        t_reset;
        t_reads;
        t_addressed_register_write;
        t_legacy;
        t_lock;
        t_unlock;
        tally_and_finish;
    end
endmodule // tb_flash_volatile_config_lock
